// file: logic/csc_pkg.sv
/*
  constants, field layouts and carrier types shared by the converter
  sequence control block and its clock divider.
  assumes a 32-bit apb register bus and a single 25 MHz cpu clock.
*/
package csc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CFG_IDX      = 12'h04C;            // config register index
  localparam logic [11:0] RATE_IDX     = 12'h04E;            // interval register index
  localparam logic [11:0] SETTLE_IDX   = 12'h050;            // settling register index
  localparam logic [11:0] CFG_ADDR     = {CFG_IDX[9:0], 2'b00};
  localparam logic [11:0] RATE_ADDR    = {RATE_IDX[9:0], 2'b00};
  localparam logic [11:0] SETTLE_ADDR  = {SETTLE_IDX[9:0], 2'b00};
  localparam logic [11:0] IRQ_STS_ADDR = 12'h180;            // sticky event bits
  localparam logic [11:0] IRQ_MSK_ADDR = 12'h184;            // event mask

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          CFG_READY_BIT = 6;                  // done flag position
  localparam logic [7:0]  CFG_RESET     = 8'h07;
  localparam logic [15:0] RATE_RESET    = 16'h0167;
  localparam logic [15:0] SETTLE_RESET  = 16'h002F;
  localparam int          EVT_DONE_BIT  = 0;                  // conversion complete
  localparam int          EVT_MISS_BIT  = 1;                  // start slot lost while busy
  localparam logic [1:0]  MASK_RESET    = 2'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [7:0]  CONV_TICKS    = 8'h10;              // converter clocks per sample

  // converter clock divider encodings
  localparam logic [1:0]  DIV_BY_1 = 2'h0;
  localparam logic [1:0]  DIV_BY_2 = 2'h1;
  localparam logic [1:0]  DIV_BY_4 = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       analogKeepPowered;     // bit 7
    logic       conversionDoneFlag;    // bit 6
    logic [1:0] converterClockDivider; // bits 5:4
    logic       conversionInProgress;  // bit 3
    logic       completionIrqEnable;   // bit 2
    logic       referenceBufferOn;     // bit 1
    logic       converterEnable;       // bit 0
  } csc_cfg_t;

  typedef struct packed {
    logic converterEnable;   // converter hardware active
    logic referenceBufferOn; // buffer drives the reference output pin
    logic analogPowered;     // analog section supply
    logic muxSwitch;         // one-cycle pulse: input mux switches
    logic convStart;         // one-cycle pulse: sampling begins
  } csc_ana_t;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_WAIT    = 2'b01,
    ST_SETTLE  = 2'b10,
    ST_CONVERT = 2'b11
  } csc_state_t;

endpackage

// file: logic/csc_clock_divider.sv
/*
  converter clock divider: one-cycle tick at the cpu clock divided by
  one, two or four.
  assumes divSel is held steady while run is high.
*/
`timescale 1ns/1ps
module csc_clock_divider
  import csc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] divSel,
  output logic            tick
);

  // ****************************************
  // divider state
  // ****************************************
  logic [1:0] cnt_q;   // phase within one converter clock
  logic [1:0] cnt_d;
  logic       tick_q;  // registered tick
  logic       tick_d;

  // next phase and tick
  always_comb begin
    cnt_d  = 2'h0;
    tick_d = 1'b0;
    if (run) begin
      case (divSel)
        DIV_BY_1: begin
          tick_d = 1'b1;
        end
        DIV_BY_2: begin
          cnt_d  = {1'b0, ~cnt_q[0]};
          tick_d = cnt_q[0];
        end
        default: begin
          // reserved code runs as divide by four, the slowest safe rate
          cnt_d  = cnt_q + 2'h1;
          tick_d = (cnt_q == 2'h3);
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// file: logic/csc_converter_sequence_control.sv
/*
  converter sequence control: apb registers, conversion pacing,
  settling wait, busy and done status, completion interrupt and
  analog power control.
  assumes apb signals synchronous to ref_clk and software that keeps
  the reserved divider code out of the config register.
*/
// Local design decision: the APB slave port.
//
// Overview of operation
// - enable bit activates converter hardware
// - bit one turns reference buffer on
// - interrupt enable gates completion interrupt
// - busy bit high during conversion cycle
// - divider field selects divide one two four
// - completion sets done flag, raises interrupt
// - analog section off after conversion unless kept
// - conversions spaced interval plus one clocks
// - settle wait value plus one clocks
`timescale 1ns/1ps
module csc_converter_sequence_control
  import csc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  output csc_ana_t         anaCtl
);

  // ****************************************
  // declarations
  // ****************************************
  csc_cfg_t    cfg_q;          // converter config, busy bit unused here
  csc_cfg_t    cfg_d;
  logic [15:0] rate_q;         // conversion interval
  logic [15:0] rate_d;
  logic [15:0] settle_q;       // settling delay
  logic [15:0] settle_d;
  logic [1:0]  evt_q;          // sticky events
  logic [1:0]  evt_d;
  logic [1:0]  mask_q;         // event mask
  logic [1:0]  mask_d;
  logic        pready_q;       // one wait state on every access
  logic        pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        irq_q;
  logic        irq_d;
  csc_ana_t    ana_q;
  csc_ana_t    ana_d;
  csc_state_t  state_q;        // sequencer state
  csc_state_t  state_d;
  logic [15:0] periodCnt_q;    // start-to-start pacing
  logic [15:0] periodCnt_d;
  logic [15:0] settleCnt_q;    // clocks spent settling
  logic [15:0] settleCnt_d;
  logic [7:0]  tickCnt_q;      // converter clocks spent sampling
  logic [7:0]  tickCnt_d;
  logic        busy_q;         // conversion in progress
  logic        busy_d;
  logic        convTick;       // converter clock tick
  logic        startSlot;      // pacing counter wrapped
  logic        convDone;       // conversion finishes this cycle
  logic        access;         // apb access phase, before pready
  logic        wrEn;           // write commits this edge
  logic        cfgWr;
  logic        stsWr;

  // true for a mapped register address
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == CFG_ADDR) || (a == RATE_ADDR) || (a == SETTLE_ADDR) ||
               (a == IRQ_STS_ADDR) || (a == IRQ_MSK_ADDR);
  endfunction

  // busy states of the sequencer
  function automatic logic isBusy(input csc_state_t s);
    isBusy = (s == ST_SETTLE) || (s == ST_CONVERT);
  endfunction

  // ****************************************
  // converter clock
  // ****************************************
  csc_clock_divider uDivider (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (cfg_q.converterEnable),
    .divSel  (cfg_q.converterClockDivider),
    .tick    (convTick)
  );

  // ****************************************
  // apb slave
  // ****************************************
  assign access = psel && penable && !pready_q;
  assign wrEn   = psel && penable && pready_q && pwrite;
  assign cfgWr  = wrEn && (paddr == CFG_ADDR);
  assign stsWr  = wrEn && (paddr == IRQ_STS_ADDR);

  // read data and response, ready one cycle into the access phase
  always_comb begin
    pready_d  = access;
    pslverr_d = access && !isMapped(paddr);
    prdata_d  = 32'h0;
    if (access && !pwrite) begin
      case (paddr)
        CFG_ADDR: begin
          prdata_d[7:0] = {cfg_q.analogKeepPowered, cfg_q.conversionDoneFlag,
                           cfg_q.converterClockDivider, busy_q,
                           cfg_q.completionIrqEnable, cfg_q.referenceBufferOn,
                           cfg_q.converterEnable};
        end
        RATE_ADDR: begin
          prdata_d[15:0] = rate_q;
        end
        SETTLE_ADDR: begin
          prdata_d[15:0] = settle_q;
        end
        IRQ_STS_ADDR: begin
          prdata_d[1:0] = evt_q;
        end
        IRQ_MSK_ADDR: begin
          prdata_d[1:0] = mask_q;
        end
        default: begin
          prdata_d = 32'h0;                      // unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  assign startSlot = cfg_q.converterEnable && (periodCnt_q == rate_q);
  assign convDone  = (state_q == ST_CONVERT) && convTick &&
                     (tickCnt_q == CONV_TICKS - 8'h01);

  // pacing runs freely while enabled so the slot grid never drifts
  always_comb begin
    state_d     = state_q;
    periodCnt_d = 16'h0;
    settleCnt_d = settleCnt_q;
    tickCnt_d   = tickCnt_q;
    if (cfg_q.converterEnable) begin
      periodCnt_d = startSlot ? 16'h0 : periodCnt_q + 16'h1;
    end
    case (state_q)
      ST_OFF: begin
        if (cfg_q.converterEnable) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (startSlot) begin
          state_d     = ST_SETTLE;
          settleCnt_d = 16'h0;
        end
      end
      ST_SETTLE: begin
        settleCnt_d = settleCnt_q + 16'h1;
        if (settleCnt_q == settle_q) begin
          state_d   = ST_CONVERT;
          tickCnt_d = 8'h0;
        end
      end
      ST_CONVERT: begin
        if (convTick) begin
          tickCnt_d = tickCnt_q + 8'h01;
        end
        if (convDone) begin
          state_d = ST_WAIT;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    // clearing the enable aborts any conversion at once
    if (!cfg_q.converterEnable) begin
      state_d = ST_OFF;
    end
    busy_d = isBusy(state_d);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_OFF;
      periodCnt_q <= 16'h0;
      settleCnt_q <= 16'h0;
      tickCnt_q   <= 8'h0;
      busy_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      periodCnt_q <= periodCnt_d;
      settleCnt_q <= settleCnt_d;
      tickCnt_q   <= tickCnt_d;
      busy_q      <= busy_d;
    end
  end

  // ****************************************
  // registers, status and interrupt
  // ****************************************
  // done flag: set beats a clearing write in the same cycle
  always_comb begin
    cfg_d    = cfg_q;
    rate_d   = rate_q;
    settle_d = settle_q;
    mask_d   = mask_q;
    evt_d    = evt_q;
    if (cfgWr) begin
      cfg_d.analogKeepPowered     = pwdata[7];
      cfg_d.converterClockDivider = pwdata[5:4];
      cfg_d.completionIrqEnable   = pwdata[2];
      cfg_d.referenceBufferOn     = pwdata[1];
      cfg_d.converterEnable       = pwdata[0];
      if (!pwdata[CFG_READY_BIT]) begin
        cfg_d.conversionDoneFlag = 1'b0;
      end
    end
    cfg_d.conversionInProgress = 1'b0;                         // status lives in busy_q
    if (wrEn && (paddr == RATE_ADDR)) begin
      rate_d = pwdata[15:0];
    end
    if (wrEn && (paddr == SETTLE_ADDR)) begin
      settle_d = pwdata[15:0];
    end
    if (wrEn && (paddr == IRQ_MSK_ADDR)) begin
      mask_d = pwdata[1:0];
    end
    if (stsWr) begin
      evt_d = evt_q & ~pwdata[1:0];
    end
    if (convDone) begin
      cfg_d.conversionDoneFlag = 1'b1;
      evt_d[EVT_DONE_BIT]      = 1'b1;
    end
    if (startSlot && isBusy(state_q)) begin
      evt_d[EVT_MISS_BIT] = 1'b1;                              // slot lost, rate too fast
    end
    irq_d = cfg_q.completionIrqEnable && ((evt_q & mask_q) != 2'h0);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q    <= CFG_RESET;
      rate_q   <= RATE_RESET;
      settle_q <= SETTLE_RESET;
      mask_q   <= MASK_RESET;
      evt_q    <= 2'h0;
      irq_q    <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      rate_q   <= rate_d;
      settle_q <= settle_d;
      mask_q   <= mask_d;
      evt_q    <= evt_d;
      irq_q    <= irq_d;
    end
  end

  // ****************************************
  // analog controls
  // ****************************************
  always_comb begin
    ana_d.converterEnable   = cfg_q.converterEnable;
    ana_d.referenceBufferOn = cfg_q.referenceBufferOn;
    ana_d.analogPowered     = cfg_q.converterEnable &&
                              (cfg_q.analogKeepPowered || isBusy(state_d));
    ana_d.muxSwitch         = (state_q == ST_WAIT) && (state_d == ST_SETTLE);
    ana_d.convStart         = (state_q == ST_SETTLE) && (state_d == ST_CONVERT);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ana_q <= '0;
    end else begin
      ana_q <= ana_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign anaCtl  = ana_q;

  // ****************************************
  // checks
  // ****************************************
  logic [15:0] gapCnt_q;    // clocks since the previous start slot
  logic        gapSeen_q;   // a previous slot exists
  logic        div4Run;     // divide by four selected while running
  // tick spacing only holds while the divider code and enable stay put
  assign div4Run = cfg_q.converterEnable && (cfg_q.converterClockDivider == DIV_BY_4);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gapCnt_q  <= 16'h0;
      gapSeen_q <= 1'b0;
    end else begin
      gapCnt_q  <= startSlot ? 16'h0 : gapCnt_q + 16'h1;
      gapSeen_q <= cfg_q.converterEnable && (gapSeen_q || startSlot);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence settleEnter;
    ana_q.muxSwitch;
  endsequence
  sequence settleLeave;
    state_q == ST_CONVERT;
  endsequence

  busy_tracks_a: assert property (busy_q == isBusy(state_q))
    else $error("busy bit disagrees with sequencer state");
  // outputs lag the config by one edge, so skip the edge that leaves reset
  enable_out_a: assert property (!$past(rst) |->
      ana_q.converterEnable == $past(cfg_q.converterEnable))
    else $error("converter enable output wrong");
  refbuf_out_a: assert property (!$past(rst) |->
      ana_q.referenceBufferOn == $past(cfg_q.referenceBufferOn))
    else $error("reference buffer output wrong");
  irq_gated_a: assert property (!cfg_q.completionIrqEnable |=> !irq_q)
    else $error("interrupt raised while disabled");
  div_four_a: assert property ((convTick && div4Run) ##1 div4Run [*3] |=> convTick &&
      !$past(convTick) && !$past(convTick, 2) && !$past(convTick, 3))
    else $error("divide by four tick spacing wrong");
  done_sets_a: assert property (convDone |=> cfg_q.conversionDoneFlag && irq_q == 1'b0
      ##1 (irq_q == (cfg_q.completionIrqEnable && mask_q[EVT_DONE_BIT]) || !evt_q[EVT_DONE_BIT]))
    else $error("completion did not set done flag and interrupt");
  power_down_a: assert property ((convDone && !cfg_q.analogKeepPowered && !cfgWr)
      |=> !ana_q.analogPowered)
    else $error("analog section left powered after conversion");
  keep_powered_a: assert property ((cfg_q.analogKeepPowered && cfg_q.converterEnable
      && !cfgWr) |=> ana_q.analogPowered)
    else $error("analog section dropped while kept powered");
  slot_spacing_a: assert property ((startSlot && gapSeen_q && $stable(rate_q))
      |-> gapCnt_q == rate_q)
    else $error("start slot spacing wrong");
  rate_mirror_a: assert property ((pready_q && !pwrite && psel && paddr == RATE_ADDR)
      |-> prdata_q[15:0] == rate_q)
    else $error("interval readback differs from held value");
  settle_time_a: assert property (settleEnter ##0 (state_q == ST_SETTLE) [*1] ##0
      $stable(settle_q) |-> settleCnt_q == 16'h0)
    else $error("settle count did not start");
  settle_exit_a: assert property ((state_q == ST_SETTLE) ##1 settleLeave
      |-> $past(settleCnt_q) == settle_q)
    else $error("settle wait length wrong");
  done_hold_a: assert property ((cfg_q.conversionDoneFlag && !(cfgWr &&
      !pwdata[CFG_READY_BIT])) |=> cfg_q.conversionDoneFlag)
    else $error("done flag dropped without a clearing write");

endmodule

// file: tb/csc_analog_model.sv
/*
  behavioural model of the analog converter section: watches the
  control pulses and power level and measures their spacing.
  assumes one ref_clk domain shared with the control block.
*/
`timescale 1ns/1ps
module csc_analog_model
  import csc_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     rst,
  input  wire csc_ana_t anaCtl,
  output logic [15:0]   muxCount_q,
  output logic [15:0]   startCount_q,
  output logic [15:0]   dropCount_q,
  output logic [15:0]   slotGap_q,
  output logic [15:0]   settleLen_q,
  output logic [15:0]   convLen_q
);
  // ****************************************
  // measurement
  // ****************************************
  logic [15:0] cyc_q;      // free cycle count
  logic [15:0] lastMux_q;  // cycle of last mux switch
  logic [15:0] lastConv_q; // cycle of last sampling start
  logic        powered_q;  // analog supply, one cycle late

  // one process: the model only observes, so no next-state split
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {cyc_q, lastMux_q, lastConv_q, powered_q} <= '0;
      {muxCount_q, startCount_q, dropCount_q} <= '0;
      {slotGap_q, settleLen_q, convLen_q} <= '0;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
      powered_q <= anaCtl.analogPowered;
      // slot spacing, mux to mux
      if (anaCtl.muxSwitch) begin
        muxCount_q <= muxCount_q + 16'h0001;
        slotGap_q <= cyc_q - lastMux_q;
        lastMux_q <= cyc_q;
      end
      // settling time, mux to sampling start
      if (anaCtl.convStart) begin
        startCount_q <= startCount_q + 16'h0001;
        settleLen_q <= cyc_q - lastMux_q;
        lastConv_q <= cyc_q;
      end
      // supply drop marks the end of a conversion
      if (powered_q && !anaCtl.analogPowered) begin
        dropCount_q <= dropCount_q + 16'h0001;
        convLen_q <= cyc_q - lastConv_q;
      end
    end
  end
endmodule

// file: tb/tb_converter_sequence_control.sv
/*
  self-checking bench for the converter sequence control block.
  assumes an apb master of its own and the analog section model.
*/
`timescale 1ns/1ps
module tb_converter_sequence_control
  import csc_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  csc_ana_t    anaCtl;
  logic [15:0] muxCnt, startCnt, dropCnt, gap, settle, convLen;
  logic [31:0] rdat;      // last read data
  logic        rerr;      // last error response
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  csc_converter_sequence_control i_csc_converter_sequence_control (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .anaCtl(anaCtl));

  csc_analog_model i_csc_analog_model (
    .ref_clk(ref_clk), .rst(rst), .anaCtl(anaCtl), .muxCount_q(muxCnt),
    .startCount_q(startCnt), .dropCount_q(dropCnt), .slotGap_q(gap),
    .settleLen_q(settle), .convLen_q(convLen));

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // hang guard: the tests need some 2000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer; pready, read data and response are the values
  // sampled at the rising edge that ends the access, and only then is
  // the request dropped; a slave that never answers meets the hang guard
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for the next model event: 0 mux, 1 start, 2 supply drop
  task automatic wait_evt(input int k);
    logic [15:0] t;
    int n;
    t = (k == 0 ? muxCnt : k == 1 ? startCnt : dropCnt) + 16'h0001;
    n = 0;
    while ((k == 0 ? muxCnt : k == 1 ? startCnt : dropCnt) !== t && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("event wait", 32'h1, 32'(n < 2000));
  endtask

  // irq is registered behind the status bits
  task automatic chk_irq(input logic ex);
    repeat (2) @(negedge ref_clk);
    chk("irq", 32'(ex), 32'(irq));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  logic [31:0] cfg;    // config value written in the divider loop
  logic [15:0] snap;   // counter snapshot
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values
    xfer(1'b0, CFG_ADDR, 32'h0);
    chk("config reset", 32'h07, rdat);
    xfer(1'b0, RATE_ADDR, 32'h0);
    chk("interval reset", 32'h0167, rdat);
    xfer(1'b0, SETTLE_ADDR, 32'h0);
    chk("settle reset", 32'h002F, rdat);
    xfer(1'b0, IRQ_MSK_ADDR, 32'h0);
    chk("mask reset", 32'h1, rdat);
    chk("converter on", 32'h1, 32'(anaCtl.converterEnable));
    chk("ref buffer on", 32'h1, 32'(anaCtl.referenceBufferOn));
    // shorter pacing, read back through the mirror
    xfer(1'b1, RATE_ADDR, 32'h000000C0);
    xfer(1'b1, SETTLE_ADDR, 32'h00000003);
    xfer(1'b0, RATE_ADDR, 32'h0);
    chk("interval mirror", 32'h00C0, rdat);
    // unmapped place answers with an error and zero data
    xfer(1'b0, 12'h200, 32'h0);
    chk("unmapped error", 32'h1, 32'(rerr));
    chk("unmapped data", 32'h0, rdat);
    // every legal divider code; the reserved code is never written
    for (int d = 0; d < 3; d++) begin
      cfg = 32'h07 | (d << 4);
      xfer(1'b1, CFG_ADDR, cfg);
      wait_evt(1);
      xfer(1'b0, CFG_ADDR, 32'h0);
      chk("busy during conversion", 32'h1, 32'(rdat[3]));
      wait_evt(2);
      chk("settle length", 32'h4, 32'(settle));
      // first converter tick may fall in the very first sampling cycle
      chk("conversion length", 32'h1, 32'(convLen > ((int'(CONV_TICKS) - 1) << d) &&
          convLen <= (int'(CONV_TICKS) << d)));
      if (d > 0) begin
        chk("slot spacing", 32'h00C1, 32'(gap));
      end
      xfer(1'b0, CFG_ADDR, 32'h0);
      chk("done and idle", 32'h40 | cfg, rdat);
      chk_irq(1'b1);
      xfer(1'b1, CFG_ADDR, cfg | 32'h40);
      xfer(1'b0, CFG_ADDR, 32'h0);
      chk("done holds", 32'h1, 32'(rdat[6]));
      xfer(1'b1, CFG_ADDR, cfg);
      xfer(1'b0, CFG_ADDR, 32'h0);
      chk("done cleared", 32'h0, 32'(rdat[6]));
      xfer(1'b1, IRQ_STS_ADDR, 32'h3);
      chk_irq(1'b0);
    end
    // masked event, then unmasked, then cleared
    xfer(1'b1, IRQ_MSK_ADDR, 32'h0);
    wait_evt(2);
    xfer(1'b0, IRQ_STS_ADDR, 32'h0);
    chk("event status", 32'h1, rdat & 32'h1);
    chk_irq(1'b0);
    xfer(1'b1, IRQ_MSK_ADDR, 32'h1);
    chk_irq(1'b1);
    xfer(1'b1, IRQ_STS_ADDR, 32'h1);
    chk_irq(1'b0);
    // interrupt enable off: completion still flags, no interrupt
    xfer(1'b1, CFG_ADDR, 32'h03);
    wait_evt(2);
    chk_irq(1'b0);
    xfer(1'b0, CFG_ADDR, 32'h0);
    chk("done without irq", 32'h1, 32'(rdat[6]));
    // analog section kept powered across conversions
    xfer(1'b1, CFG_ADDR, 32'h83);
    wait_evt(1);
    snap = dropCnt;
    wait_evt(0);
    chk("kept powered", 32'h1, 32'(anaCtl.analogPowered));
    chk("no supply drop", 32'(snap), 32'(dropCnt));
    // converter and buffer off, pacing stops
    xfer(1'b1, CFG_ADDR, 32'h00);
    repeat (2) @(negedge ref_clk);
    chk("converter off", 32'h0, 32'(anaCtl.converterEnable));
    chk("ref buffer off", 32'h0, 32'(anaCtl.referenceBufferOn));
    chk("supply off", 32'h0, 32'(anaCtl.analogPowered));
    snap = muxCnt;
    repeat (400) @(posedge ref_clk);
    chk("no slots when off", 32'(snap), 32'(muxCnt));
    // pacing faster than one conversion: slots come while busy
    xfer(1'b1, RATE_ADDR, 32'h00000010);
    xfer(1'b1, CFG_ADDR, 32'h00000021);
    wait_evt(2);
    xfer(1'b0, IRQ_STS_ADDR, 32'h0);
    chk("missed slot", 32'h2, rdat & 32'h2);
    finish_test();
  end
endmodule
